/* File: spi_port_pkg.sv */
// Shared constants, carriers and helpers for the serial port.
// Assumes one system clock at 20 MHz and a mode 0 link.
package spi_port_pkg;

   // ---------------------------------------------------------------
   // Widths and counts
   // ---------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int DIV_W = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam int RX_DEPTH_DEF = 2;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SCK_HALF_NS = 200;
   // Least half period, rounded up to whole system cycles
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic SS_RST = 1'b1;
   localparam logic PIN_RST = 1'b0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic enable;
      logic master;
      logic transfer_irq_enable;
   } ctrl_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW = 2'b01,
      ST_HIGH = 2'b10
   } mst_state_t;

   // Level filter: take a new value once two stages agree
   function automatic logic agree(input logic lvl, input logic a, input logic b);
      return (a == b) ? b : lvl;
   endfunction : agree

endpackage : spi_port_pkg

/* File: rx_byte_buf.sv */
// Small receive buffer with valid/ready on both sides.
// Assumes one clock; the filler may force a drop of the oldest entry.
module rx_byte_buf #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   input wire logic ovw,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0] ent_r [DEPTH];
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic out_valid_r;
   logic full;
   logic push;
   logic pop;

   // ---------------------------------------------------------------
   // Occupancy
   // ---------------------------------------------------------------
   assign full = (count_r == CW'(DEPTH));
   assign in_ready = !full;
   assign pop = (out_valid_r && out_ready) || (ovw && full && in_valid);
   assign push = in_valid && (!full || pop);
   assign count_nxt = count_r + CW'(push) - CW'(pop);
   assign out_valid = out_valid_r;
   assign out_data = ent_r[0];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_r <= '0;
         out_valid_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         out_valid_r <= (count_nxt != '0);
      end
   end

   // Head stays put until popped, so the last byte stays readable
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            ent_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            if (push && (CW'(i) == count_r - CW'(pop))) begin
               ent_r[i] <= in_data;
            end else if (pop && (i < DEPTH - 1)) begin
               ent_r[i] <= ent_r[(i + 1) % DEPTH];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_head_hold;
      out_valid && !out_ready && !(ovw && in_valid) |=> out_valid && $stable(out_data);
   endproperty
   a_head_hold: assert property (p_head_hold) else $error("held byte changed");

   property p_drop_oldest;
      in_valid && ovw && full |=> full;
   endproperty
   a_drop_oldest: assert property (p_drop_oldest) else $error("overrun lost fill");

   c_buf_full: cover property (full && in_valid && ovw);

endmodule : rx_byte_buf

/* File: spi_master_slave_port.sv */
// Byte-wide serial port working as master or slave, receive buffered.
// Assumes SCK_IN carries the SCK pin level and clocks the slave shifter,
// SS_N_IN is the slave select pin, and software handles its own SS as master.
module spi_master_slave_port #(
   parameter int SCK_HALF = spi_port_pkg::SCK_HALF_CYC,
   parameter int RX_DEPTH = spi_port_pkg::RX_DEPTH_DEF
) (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic SCK_IN,
   input wire spi_port_pkg::ctrl_t SERIAL_CONTROL_REG,
   input wire logic [7:0] SERIAL_DATA_REG,
   input wire logic DATA_WR,
   input wire logic DONE_CLR,
   output logic [7:0] RX_DATA,
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic TRANSFER_DONE_FLAG,
   output logic IRQ_REQ,
   output logic TX_BUSY,
   input wire logic SS_N_IN,
   input wire logic MOSI_IN,
   output logic MOSI_OUT,
   output logic MOSI_OE,
   input wire logic MISO_IN,
   output logic MISO_OUT,
   output logic MISO_OE,
   output logic SCK_OUT,
   output logic SCK_OE
);
   import spi_port_pkg::*;

   logic ss_s1_r, ss_s2_r, ss_s3_r, ss_lvl_r;
   logic mi_s1_r, mi_s2_r, mi_s3_r, miso_lvl_r;
   logic tg_s1_r, tg_s2_r, tg_s3_r, tg_lvl_r;
   logic link_rst_n_r;
   logic [2:0] lk_cnt_r;
   logic [6:0] lk_shift_r;
   logic [2:0] lk_out_idx_r;
   logic lk_tgl_r;
   logic [7:0] lk_byte_r;
   mst_state_t state_r;
   logic [DIV_W-1:0] div_r;
   logic [2:0] bit_r;
   logic [7:0] mtx_r;
   logic [7:0] mrx_r;
   logic sck_r, mosi_r;
   logic sck_oe_r, mosi_oe_r, miso_oe_r;
   logic [7:0] tx_hold_r;
   logic done_flag_r, irq_r, busy_r;
   logic half_end, mst_done, start, slv_evt;
   logic push_valid, buf_in_ready, flag_nxt;
   logic [7:0] push_data;
   logic en, is_master;

   assign en = SERIAL_CONTROL_REG.enable;
   assign is_master = SERIAL_CONTROL_REG.master;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         ss_s1_r <= SS_RST;
         ss_s2_r <= SS_RST;
         ss_s3_r <= SS_RST;
         ss_lvl_r <= SS_RST;
         mi_s1_r <= PIN_RST;
         mi_s2_r <= PIN_RST;
         mi_s3_r <= PIN_RST;
         miso_lvl_r <= PIN_RST;
      end else begin
         ss_s1_r <= SS_N_IN;
         ss_s2_r <= ss_s1_r;
         ss_s3_r <= ss_s2_r;
         ss_lvl_r <= agree(ss_lvl_r, ss_s2_r, ss_s3_r);
         mi_s1_r <= MISO_IN;
         mi_s2_r <= mi_s1_r;
         mi_s3_r <= mi_s2_r;
         miso_lvl_r <= agree(miso_lvl_r, mi_s2_r, mi_s3_r);
      end
   end

   // Held low through reset; clears the link side toggle
   always_ff @(posedge CLK_SYS) begin
      link_rst_n_r <= RESETN;
   end

   // ---------------------------------------------------------------
   // Slave shifter on the link clock
   // ---------------------------------------------------------------
   // SS high ends the frame, so no SCK edge is needed to restart
   always_ff @(posedge SCK_IN or posedge SS_N_IN) begin
      if (SS_N_IN) begin
         lk_cnt_r <= 3'h0;
         lk_shift_r <= 7'h00;
      end else begin
         lk_cnt_r <= lk_cnt_r + 3'h1;
         lk_shift_r <= {lk_shift_r[5:0], MOSI_IN};
      end
   end

   always_ff @(posedge SCK_IN or negedge link_rst_n_r) begin
      if (!link_rst_n_r) begin
         lk_tgl_r <= 1'b0;
         lk_byte_r <= DATA_RST;
      end else if (!SS_N_IN && (lk_cnt_r == LAST_BIT)) begin
         lk_tgl_r <= !lk_tgl_r;
         lk_byte_r <= {lk_shift_r, MOSI_IN};
      end
   end

   // Trailing edge moves to the next outgoing bit
   always_ff @(negedge SCK_IN or posedge SS_N_IN) begin
      if (SS_N_IN) begin
         lk_out_idx_r <= 3'h0;
      end else begin
         lk_out_idx_r <= lk_out_idx_r + 3'h1;
      end
   end

   // Combinational so bit 7 is ready before the first leading edge
   assign MISO_OUT = tx_hold_r[LAST_BIT - lk_out_idx_r];

   // ---------------------------------------------------------------
   // Slave byte event into the system domain
   // ---------------------------------------------------------------
   // Byte word is stable for eight SCK periods after the toggle
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_s3_r <= 1'b0;
         tg_lvl_r <= 1'b0;
      end else begin
         tg_s1_r <= lk_tgl_r;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
         tg_lvl_r <= agree(tg_lvl_r, tg_s2_r, tg_s3_r);
      end
   end

   // Counts only once the late stages agree, as for the pins
   assign slv_evt = (agree(tg_lvl_r, tg_s2_r, tg_s3_r) != tg_lvl_r) && en && !is_master;

   // ---------------------------------------------------------------
   // Master clock generator
   // ---------------------------------------------------------------
   assign half_end = (div_r == DIV_W'(SCK_HALF - 1));
   assign mst_done = en && (state_r == ST_HIGH) && half_end && (bit_r == LAST_BIT);
   // No SS drive here; buffer space stalls the start
   assign start = DATA_WR && en && is_master && (state_r == ST_IDLE) && buf_in_ready;

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         state_r <= ST_IDLE;
         div_r <= '0;
         bit_r <= 3'h0;
         mtx_r <= DATA_RST;
         mrx_r <= DATA_RST;
         sck_r <= 1'b0;
         mosi_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (start) begin
                  mtx_r <= SERIAL_DATA_REG;
                  mosi_r <= SERIAL_DATA_REG[7];
                  bit_r <= 3'h0;
                  div_r <= '0;
                  state_r <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (half_end) begin
                  sck_r <= 1'b1;
                  div_r <= '0;
                  state_r <= ST_HIGH;
               end else begin
                  div_r <= div_r + DIV_W'(1);
               end
            end
            ST_HIGH: begin
               if (half_end) begin
                  sck_r <= 1'b0;
                  div_r <= '0;
                  mrx_r <= {mrx_r[6:0], miso_lvl_r};
                  if (bit_r == LAST_BIT) begin
                     state_r <= ST_IDLE;
                  end else begin
                     bit_r <= bit_r + 3'h1;
                     mtx_r <= {mtx_r[6:0], 1'b0};
                     mosi_r <= mtx_r[6];
                     state_r <= ST_LOW;
                  end
               end else begin
                  div_r <= div_r + DIV_W'(1);
               end
            end
            default: state_r <= ST_IDLE;
         endcase
         // Disabling aborts a byte in flight
         if (!en) begin
            state_r <= ST_IDLE;
            sck_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmit holding byte
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         tx_hold_r <= DATA_RST;
      end else if (DATA_WR && (state_r == ST_IDLE)) begin
         tx_hold_r <= SERIAL_DATA_REG;
      end
   end

   // ---------------------------------------------------------------
   // Pin direction
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         sck_oe_r <= 1'b0;
         mosi_oe_r <= 1'b0;
         miso_oe_r <= 1'b0;
      end else begin
         sck_oe_r <= en && is_master;
         mosi_oe_r <= en && is_master;
         miso_oe_r <= en && !is_master && !ss_lvl_r;
      end
   end

   // ---------------------------------------------------------------
   // Receive buffer
   // ---------------------------------------------------------------
   assign push_valid = mst_done || slv_evt;
   assign push_data = mst_done ? {mrx_r[6:0], miso_lvl_r} : lk_byte_r;
   // Slave cannot stall the far master, so it overwrites the oldest
   rx_byte_buf #(.W(DATA_W), .DEPTH(RX_DEPTH)) u_rx_buf (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .in_valid(push_valid),
      .in_ready(buf_in_ready),
      .in_data(push_data),
      .ovw(!is_master),
      .out_valid(RX_VALID),
      .out_ready(RX_READY),
      .out_data(RX_DATA)
   );

   // ---------------------------------------------------------------
   // Done flag, interrupt request, busy
   // ---------------------------------------------------------------
   assign flag_nxt = push_valid || (done_flag_r && !DONE_CLR);
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         done_flag_r <= 1'b0;
         irq_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         done_flag_r <= flag_nxt;
         irq_r <= flag_nxt && SERIAL_CONTROL_REG.transfer_irq_enable;
         busy_r <= en && (start || ((state_r != ST_IDLE) && !mst_done));
      end
   end

   assign TRANSFER_DONE_FLAG = done_flag_r;
   assign IRQ_REQ = irq_r;
   assign TX_BUSY = busy_r;
   assign SCK_OUT = sck_r;
   assign MOSI_OUT = mosi_r;
   assign SCK_OE = sck_oe_r;
   assign MOSI_OE = mosi_oe_r;
   assign MISO_OE = miso_oe_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [3:0] rise_cnt_r;
   logic sck_q_r;
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         rise_cnt_r <= 4'h0;
         sck_q_r <= 1'b0;
      end else begin
         sck_q_r <= sck_r;
         if (start) begin
            rise_cnt_r <= 4'h0;
         end else if (sck_r && !sck_q_r) begin
            rise_cnt_r <= rise_cnt_r + 4'h1;
         end
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   property p_start_shift;
      start |=> (state_r == ST_LOW) && (MOSI_OUT == $past(SERIAL_DATA_REG[7]));
   endproperty
   a_start_shift: assert property (p_start_shift) else $error("write did not start");
   property p_eight_edges;
      mst_done |=> rise_cnt_r == 4'h8;
   endproperty
   a_eight_edges: assert property (p_eight_edges) else $error("not eight clocks");
   property p_clock_stops;
      mst_done |=> (state_r == ST_IDLE) && !SCK_OUT && TRANSFER_DONE_FLAG;
   endproperty
   a_clock_stops: assert property (p_clock_stops) else $error("clock not stopped");
   property p_idle_low;
      state_r == ST_IDLE |-> !SCK_OUT;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("SCK not idle low");
   property p_irq_follows;
      1'b1 |-> IRQ_REQ == (TRANSFER_DONE_FLAG && $past(SERIAL_CONTROL_REG.transfer_irq_enable));
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("bad interrupt");
   // A write while the last byte's flag still stands starts the next byte
   property p_next_byte;
      TRANSFER_DONE_FLAG && !TX_BUSY && DATA_WR && en && is_master && buf_in_ready |=> TX_BUSY;
   endproperty
   a_next_byte: assert property (p_next_byte) else $error("next byte refused");
   property p_miso_free;
      ss_lvl_r |=> !MISO_OE;
   endproperty
   a_miso_free: assert property (p_miso_free) else $error("MISO driven");
   property p_slave_done;
      slv_evt |=> TRANSFER_DONE_FLAG && RX_VALID;
   endproperty
   a_slave_done: assert property (p_slave_done) else $error("slave byte lost");
   property p_busy_write;
      DATA_WR && (state_r != ST_IDLE) |=> $stable(tx_hold_r);
   endproperty
   a_busy_write: assert property (p_busy_write) else $error("write during shift");
   property p_master_pins;
      en && is_master |=> SCK_OE && MOSI_OE && !MISO_OE;
   endproperty
   a_master_pins: assert property (p_master_pins) else $error("pin direction");
   property p_flag_sticky;
      TRANSFER_DONE_FLAG && !DONE_CLR |=> TRANSFER_DONE_FLAG;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

   c_master_byte: cover property (mst_done);
   c_slave_byte: cover property (slv_evt);
   c_irq: cover property ($rose(IRQ_REQ));
   c_stall: cover property (DATA_WR && en && is_master && !buf_in_ready);

endmodule : spi_master_slave_port

/* File: spi_far_end.sv */
// Far-side model: slave while the port is master, master while it is slave.
// Assumes link_clk at 48 ns, idle-low SCK, MSB first.
module spi_far_end (
   input wire logic link_clk,
   input wire logic sel_n,
   input wire logic sck_in,
   input wire logic mosi_in,
   output logic miso_drv,
   input wire logic miso_out,
   input wire logic miso_oe,
   output logic sck_drv,
   output logic ss_n_drv,
   output logic mosi_drv
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sl_tx;
   logic [7:0] sl_rx;
   int sl_rises;
   initial begin
      miso_drv = 1'b0;
      sck_drv = 1'b0;
      ss_n_drv = 1'b1;
      mosi_drv = 1'b0;
      sl_tx = 8'h00;
      sl_rx = 8'h00;
      sl_rises = 0;
   end
   // ---------------------------------------------------------------
   // Slave half
   // ---------------------------------------------------------------
   always @(negedge sel_n) begin
      sl_rises = 0;
      miso_drv = sl_tx[7];
   end
   always @(posedge sck_in) if (!sel_n) begin
      sl_rx = {sl_rx[6:0], mosi_in};
      sl_rises++;
   end
   always @(negedge sck_in) if (!sel_n && sl_rises < 8) miso_drv = sl_tx[7 - sl_rises];
   // Released line: no pull, so never leave the last bit standing
   always @(posedge link_clk) if (sel_n) miso_drv <= ~miso_drv;
   // ---------------------------------------------------------------
   // Master half
   // ---------------------------------------------------------------
   task automatic send(input logic [7:0] tx, output logic [7:0] rx);
      ss_n_drv <= 1'b0;
      // Six link cycles exceed the five system cycles MISO needs
      repeat (6) @(posedge link_clk);
      for (int i = 7; i >= 0; i--) begin
         mosi_drv <= tx[i];
         repeat (3) @(posedge link_clk);
         sck_drv <= 1'b1; // 288 ns period, under a quarter of system clock
         rx[i] = miso_oe ? miso_out : 1'bx;
         repeat (3) @(posedge link_clk);
         sck_drv <= 1'b0;
      end
      repeat (3) @(posedge link_clk);
      ss_n_drv <= 1'b1;
      mosi_drv <= ~mosi_drv;
   endtask : send
   task automatic idle_clocks(input int n);
      repeat (n) begin
         repeat (3) @(posedge link_clk);
         sck_drv <= 1'b1;
         repeat (3) @(posedge link_clk);
         sck_drv <= 1'b0;
      end
   endtask : idle_clocks
endmodule : spi_far_end

/* File: spi_master_slave_port_test.sv */
// Self-checking bench for the serial port, master then slave role.
// Assumes the far-side model and 20 MHz system clock.
module spi_master_slave_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   import spi_port_pkg::*;
   logic clk_sys, link_clk, resetn, sel_n;
   ctrl_t ctrl;
   logic [7:0] wdata, rx_data, tx, sl, got;
   logic data_wr, done_clr, rx_valid, rx_ready, done_flag, irq_req, tx_busy;
   logic mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe;
   logic miso_line, sck_line, ss_line, mosi_line;
   logic [7:0] exp_q[$];
   int bad_count, n_compared;
   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;
   initial link_clk = 1'b0;
   always #24 link_clk = ~link_clk;
   spi_master_slave_port #(.SCK_HALF(4), .RX_DEPTH(2)) u_spi_master_slave_port (
      .CLK_SYS(clk_sys), .RESETN(resetn), .SCK_IN(sck_line), .SERIAL_CONTROL_REG(ctrl),
      .SERIAL_DATA_REG(wdata), .DATA_WR(data_wr), .DONE_CLR(done_clr), .RX_DATA(rx_data),
      .RX_VALID(rx_valid), .RX_READY(rx_ready), .TRANSFER_DONE_FLAG(done_flag),
      .IRQ_REQ(irq_req), .TX_BUSY(tx_busy), .SS_N_IN(ss_line), .MOSI_IN(mosi_line),
      .MOSI_OUT(mosi_out), .MOSI_OE(mosi_oe), .MISO_IN(miso_line), .MISO_OUT(miso_out),
      .MISO_OE(miso_oe), .SCK_OUT(sck_out), .SCK_OE(sck_oe));
   spi_far_end u_spi_far_end (
      .link_clk(link_clk), .sel_n(sel_n), .sck_in(sck_out), .mosi_in(mosi_out),
      .miso_drv(miso_line), .miso_out(miso_out), .miso_oe(miso_oe), .sck_drv(sck_line),
      .ss_n_drv(ss_line), .mosi_drv(mosi_line));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string what);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic g, input logic e, input string what);
      chk_byte({7'h00, g}, {7'h00, e}, what);
   endtask : chk_bit
   task automatic wr(input logic [7:0] b);
      @(posedge clk_sys);
      wdata <= b;
      data_wr <= 1'b1;
      done_clr <= 1'b1;
      @(posedge clk_sys);
      data_wr <= 1'b0;
      done_clr <= 1'b0;
   endtask : wr
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   // Receive checker: each popped byte against the oldest note
   always @(posedge clk_sys) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            bad_count++;
            $display("[FAIL] %0t unexpected byte %h", $time, rx_data);
         end else chk_byte(rx_data, exp_q.pop_front(), "rx byte");
      end
   end
   initial begin
      #500000;
      bad_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      ctrl = 3'h0;
      wdata = 8'h00;
      data_wr = 1'b0;
      done_clr = 1'b0;
      rx_ready = 1'b1;
      sel_n = 1'b1;
      bad_count = 0;
      n_compared = 0;
      void'($urandom(32'h97c1e98a));
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk_bit(done_flag, 1'b0, "flag at reset");
      chk_bit(rx_valid, 1'b0, "rx valid at reset");
      chk_bit(miso_oe, 1'b0, "miso oe at reset");
      $display("reset test done");
      // Master bytes, one packet each, busy write in mid-byte
      for (int k = 0; k < 3; k++) begin
         tx = 8'($urandom);
         sl = 8'($urandom);
         u_spi_far_end.sl_tx = sl;
         ctrl <= (k == 1) ? 3'h6 : 3'h7;
         sel_n <= 1'b0;
         wr(tx);
         repeat (30) @(posedge clk_sys);
         chk_bit(tx_busy, 1'b1, "busy");
         chk_bit(sck_oe & mosi_oe & ~miso_oe, 1'b1, "master dirs");
         wr(~tx);
         repeat (31) @(posedge clk_sys);
         #1;
         chk_bit(done_flag, 1'b0, "flag early");
         @(posedge clk_sys);
         #1;
         chk_bit(done_flag, 1'b1, "flag late");
         exp_q.push_back(sl);
         @(posedge clk_sys);
         #1;
         chk_bit(irq_req, k != 1, "irq");
         repeat (20) @(posedge clk_sys);
         chk_byte(8'(u_spi_far_end.sl_rises), 8'h08, "sck pulses");
         chk_byte(u_spi_far_end.sl_rx, tx, "mosi byte");
         sel_n <= 1'b1;
         // SS must really rise between packets so the slave resyncs
         repeat (2) @(posedge clk_sys);
      end
      $display("master test done");
      // Slave: load with SS high, clocks ignored, then overrun
      ctrl <= 3'h5;
      rx_ready <= 1'b0;
      tx = 8'($urandom);
      wr(tx);
      u_spi_far_end.idle_clocks(4);
      repeat (6) @(posedge clk_sys);
      chk_bit(done_flag, 1'b0, "flag with SS high");
      chk_bit(miso_oe | sck_oe | mosi_oe, 1'b0, "slave dirs idle");
      for (int k = 0; k < 3; k++) begin
         sl = 8'($urandom);
         u_spi_far_end.send(sl, got);
         chk_byte(got, tx, "miso byte");
         repeat (6) @(posedge clk_sys);
         chk_bit(done_flag, 1'b1, "slave flag");
         chk_bit(irq_req, 1'b1, "slave irq");
         if (k > 0) exp_q.push_back(sl);
         tx = 8'($urandom);
         wr(tx);
      end
      rx_ready <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk_bit(rx_valid, 1'b0, "drained");
      chk_byte(8'(exp_q.size()), 8'h00, "notes left");
      $display("slave test done");
      end_of_test();
   end
endmodule : spi_master_slave_port_test
